// ==== logic/wwt_consts.svh ====
// offsets, field positions, reset values and counts of the watchdog
`ifndef WWT_CONSTS_SVH
`define WWT_CONSTS_SVH

`define WWT_OFS_CTRL      6'h00
`define WWT_OFS_RELOAD    6'h01
`define WWT_OFS_SERVICE   6'h02
`define WWT_OFS_COUNT     6'h03
`define WWT_OFS_STATUS    6'h04
`define WWT_OFS_MASK      6'h05

`define WWT_CTRL_ENABLE   0
`define WWT_CTRL_DIVSEL   1
`define WWT_CTRL_WINEN    2

`define WWT_EV_OVERFLOW   0
`define WWT_EV_BADREFRESH 1
`define WWT_EV_RESET      2

`define WWT_RST_CTRL      3'h0
`define WWT_RST_BYTE      8'h00
`define WWT_RST_EVENTS    3'h0

`define WWT_DIV_FAST_LAST 7'h01
`define WWT_DIV_SLOW_LAST 7'h7f
`define WWT_PREWARN_TICKS 6'h30
`define WWT_COUNT_TOP     16'hffff

`define WWT_RESP_OKAY     2'h0
`define WWT_RESP_SLVERR   2'h2

`endif

// ==== logic/wwt_pkg.sv ====
// types of the windowed watchdog
package wwt_pkg;
    typedef enum logic [1:0] {
        WWT_IDLE    = 2'h0,
        WWT_RUN     = 2'h1,
        WWT_PREWARN = 2'h3,
        WWT_RESET   = 2'h2
    } wwt_state_t;
endpackage

// ==== logic/wwt_top.sv ====
// windowed watchdog timer with axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "wwt_consts.svh"

module wwt_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        debug_mode,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             timeout_nmi,
    output logic             watchdog_reset_out,
    output logic             irq
);
    wwt_pkg::wwt_state_t state_q;
    logic [15:0] watchdog_counter_q;
    logic [6:0]  presc_q;
    logic [5:0]  pw_q;
    logic [2:0]  ctrl_q;
    logic [7:0]  reload_high_byte_q;
    logic [7:0]  window_bound_byte_q;
    logic [2:0]  status_q;
    logic [2:0]  status_d;
    logic [2:0]  mask_q;
    logic        aw_have_q;
    logic        w_have_q;
    logic [5:0]  waddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_fire;
    logic        w_fire;
    logic        ar_fire;
    logic        wr_go;
    logic        aw_have_d;
    logic        w_have_d;
    logic        rvalid_d;
    logic        counting;
    logic        tick;
    logic [6:0]  presc_last;
    logic        svc;
    logic        svc_run;
    logic        in_window;
    logic [7:0]  load_byte;
    logic        ev_ovf;
    logic        ev_bad;
    logic        ev_rst;
    logic        mapped_w;
    logic        mapped_r;
    logic [31:0] rd_mux;

    // ---------------- axi4-lite write channel ----------------
    assign aw_fire   = awvalid && awready;
    assign w_fire    = wvalid && wready;
    assign wr_go     = aw_have_q && w_have_q && !bvalid;
    assign aw_have_d = (aw_have_q || aw_fire) && !wr_go;
    assign w_have_d  = (w_have_q || w_fire) && !wr_go;
    assign mapped_w  = waddr_q <= `WWT_OFS_MASK;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awready   <= !aw_have_d;
            wready    <= !w_have_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waddr_q <= 6'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_fire) begin
                waddr_q <= awaddr[7:2];
            end
            if (w_fire) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `WWT_RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= mapped_w ? `WWT_RESP_OKAY : `WWT_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ---------------- axi4-lite read channel ----------------
    assign ar_fire  = arvalid && arready;
    assign rvalid_d = (rvalid && !rready) || ar_fire;
    assign mapped_r = araddr[7:2] <= `WWT_OFS_MASK;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (araddr[7:2])
            `WWT_OFS_CTRL:   rd_mux[2:0] = ctrl_q;
            `WWT_OFS_RELOAD: rd_mux[15:0] = {window_bound_byte_q,
                                             reload_high_byte_q};
            `WWT_OFS_COUNT:  rd_mux[17:0] = {watchdog_reset_out,
                                   state_q == wwt_pkg::WWT_PREWARN,
                                   watchdog_counter_q};
            `WWT_OFS_STATUS: rd_mux[2:0] = status_q;
            `WWT_OFS_MASK:   rd_mux[2:0] = mask_q;
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid  <= 1'b0;
            arready <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `WWT_RESP_OKAY;
        end else begin
            rvalid  <= rvalid_d;
            arready <= !rvalid_d;
            if (ar_fire) begin
                rdata <= rd_mux;
                rresp <= mapped_r ? `WWT_RESP_OKAY : `WWT_RESP_SLVERR;
            end
        end
    end

    // ---------------- configuration registers ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q              <= `WWT_RST_CTRL;
            reload_high_byte_q  <= `WWT_RST_BYTE;
            window_bound_byte_q <= `WWT_RST_BYTE;
            mask_q              <= `WWT_RST_EVENTS;
        end else if (wr_go) begin
            if (waddr_q == `WWT_OFS_CTRL && wstrb_q[0]) begin
                // enable is one-way: only a system reset stops the dog
                ctrl_q <= {wdata_q[2:1], ctrl_q[0] | wdata_q[0]};
            end
            if (waddr_q == `WWT_OFS_RELOAD && wstrb_q[0]) begin
                reload_high_byte_q <= wdata_q[7:0];
            end
            if (waddr_q == `WWT_OFS_RELOAD && wstrb_q[1]) begin
                window_bound_byte_q <= wdata_q[15:8];
            end
            if (waddr_q == `WWT_OFS_MASK && wstrb_q[0]) begin
                mask_q <= wdata_q[2:0];
            end
        end
    end

    // ---------------- prescaler ----------------
    assign counting   = (state_q == wwt_pkg::WWT_RUN ||
                         state_q == wwt_pkg::WWT_PREWARN) &&
                        !debug_mode;
    assign presc_last = ctrl_q[`WWT_CTRL_DIVSEL] ? `WWT_DIV_SLOW_LAST
                                                 : `WWT_DIV_FAST_LAST;
    assign tick       = counting && presc_q >= presc_last;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_q <= 7'h00;
        end else if (tick) begin
            presc_q <= 7'h00;
        end else if (counting) begin
            presc_q <= presc_q + 7'h01;
        end
    end

    // ---------------- service and window ----------------
    assign svc       = wr_go && waddr_q == `WWT_OFS_SERVICE;
    assign svc_run   = svc && state_q == wwt_pkg::WWT_RUN;
    // window includes its upper bound itself
    assign in_window = ctrl_q[`WWT_CTRL_WINEN] &&
        watchdog_counter_q <= {window_bound_byte_q, 8'h00};
    // larger bound replaces reload, shortening the period
    assign load_byte = (ctrl_q[`WWT_CTRL_WINEN] &&
                        window_bound_byte_q > reload_high_byte_q) ?
                       window_bound_byte_q : reload_high_byte_q;
    assign ev_bad    = svc_run && in_window;
    assign ev_ovf    = state_q == wwt_pkg::WWT_RUN && !svc_run && tick &&
                       watchdog_counter_q == `WWT_COUNT_TOP;
    assign ev_rst    = state_q == wwt_pkg::WWT_PREWARN && tick &&
                       pw_q == `WWT_PREWARN_TICKS - 6'h01;

    // ---------------- state machine ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= wwt_pkg::WWT_IDLE;
        end else begin
            case (state_q)
                wwt_pkg::WWT_IDLE: begin
                    if (ctrl_q[`WWT_CTRL_ENABLE]) begin
                        state_q <= wwt_pkg::WWT_RUN;
                    end
                end
                wwt_pkg::WWT_RUN: begin
                    if (ev_bad || ev_ovf) begin
                        state_q <= wwt_pkg::WWT_PREWARN;
                    end
                end
                wwt_pkg::WWT_PREWARN: begin
                    if (ev_rst) begin
                        state_q <= wwt_pkg::WWT_RESET;
                    end
                end
                wwt_pkg::WWT_RESET: state_q <= wwt_pkg::WWT_RESET;
                default: state_q <= wwt_pkg::WWT_IDLE;
            endcase
        end
    end

    // ---------------- counter ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_counter_q <= 16'h0000;
        end else if (state_q == wwt_pkg::WWT_IDLE) begin
            watchdog_counter_q <= {reload_high_byte_q, 8'h00};
        end else if (svc_run && !in_window) begin
            watchdog_counter_q <= {load_byte, 8'h00};
        end else if (tick) begin
            // both bytes wrap together, ffff rolls to 0000
            watchdog_counter_q <= watchdog_counter_q + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pw_q <= 6'h00;
        end else if (state_q == wwt_pkg::WWT_PREWARN && tick) begin
            pw_q <= pw_q + 6'h01;
        end
    end

    // ---------------- outputs and interrupts ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_nmi        <= 1'b0;
            watchdog_reset_out <= 1'b0;
        end else begin
            if (ev_ovf) begin
                timeout_nmi <= 1'b1;
            end
            if (ev_rst) begin
                watchdog_reset_out <= 1'b1;
            end
        end
    end

    // set beats a same-cycle write-one clear
    always_comb begin
        status_d = status_q;
        if (wr_go && waddr_q == `WWT_OFS_STATUS && wstrb_q[0]) begin
            status_d = status_d & ~wdata_q[2:0];
        end
        status_d[`WWT_EV_OVERFLOW]   = status_d[`WWT_EV_OVERFLOW]   | ev_ovf;
        status_d[`WWT_EV_BADREFRESH] = status_d[`WWT_EV_BADREFRESH] | ev_bad;
        status_d[`WWT_EV_RESET]      = status_d[`WWT_EV_RESET]      | ev_rst;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= `WWT_RST_EVENTS;
            irq      <= 1'b0;
        end else begin
            status_q <= status_d;
            irq      <= |(status_d & mask_q);
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_COUNT_STEP: assert property (
        tick && state_q == wwt_pkg::WWT_RUN && !svc_run
        |=> watchdog_counter_q == $past(watchdog_counter_q) + 16'h0001)
        else $error("counter did not step by one on a tick");

    AST_DIV_FAST: assert property (
        (tick && !ctrl_q[1]) ##1 (counting && !ctrl_q[1])
        |-> !tick ##1 (tick || !counting || ctrl_q[1]))
        else $error("fast tick spacing is not two clocks");

    AST_DIV_SLOW: assert property (
        (tick && ctrl_q[1]) ##1 (counting && ctrl_q[1])[*8] |-> !tick)
        else $error("slow tick came early");

    AST_SERVICE_LOAD: assert property (
        svc_run && !in_window
        |=> watchdog_counter_q == {$past(load_byte), 8'h00}
            && state_q == wwt_pkg::WWT_RUN)
        else $error("service did not load reload times 256");

    AST_OVF_NMI: assert property (
        ev_ovf |=> state_q == wwt_pkg::WWT_PREWARN && timeout_nmi
                   && watchdog_counter_q == 16'h0000)
        else $error("overflow did not raise nmi and prewarn");

    AST_PREWARN_END: assert property (
        ev_rst |=> watchdog_reset_out && pw_q == `WWT_PREWARN_TICKS)
        else $error("reset not after 30h prewarning ticks");

    AST_BAD_REFRESH: assert property (
        svc_run && ctrl_q[2] &&
        watchdog_counter_q <= {window_bound_byte_q, 8'h00}
        |=> state_q == wwt_pkg::WWT_PREWARN && !timeout_nmi)
        else $error("window refresh not punished correctly");

    AST_NO_WINDOW: assert property (
        svc_run && !ctrl_q[2] |=> state_q == wwt_pkg::WWT_RUN)
        else $error("window check acted while disabled");

    AST_DEBUG_HOLD: assert property (
        debug_mode && !svc |=> $stable(watchdog_counter_q))
        else $error("counter moved in debug mode");

    AST_PREWARN_DEAF: assert property (
        state_q == wwt_pkg::WWT_PREWARN && svc && !tick
        |=> $stable(watchdog_counter_q))
        else $error("service accepted during prewarning");

    COV_OVERFLOW: cover property (ev_ovf);
    COV_BAD_REFRESH: cover property (ev_bad);
    COV_RESET: cover property (ev_rst);
    COV_SERVICE_OK: cover property (svc_run && !in_window);
endmodule

// ==== verification/tb_windowed_watchdog_timer.sv ====
// self-checking bench of the windowed watchdog timer
`timescale 1ns/100ps
`include "wwt_consts.svh"

module tb_windowed_watchdog_timer;
    localparam logic [7:0] A_CTRL = {`WWT_OFS_CTRL, 2'b00};
    localparam logic [7:0] A_REL  = {`WWT_OFS_RELOAD, 2'b00};
    localparam logic [7:0] A_SVC  = {`WWT_OFS_SERVICE, 2'b00};
    localparam logic [7:0] A_CNT  = {`WWT_OFS_COUNT, 2'b00};
    localparam logic [7:0] A_STS  = {`WWT_OFS_STATUS, 2'b00};
    localparam logic [7:0] A_MSK  = {`WWT_OFS_MASK, 2'b00};
    localparam logic [1:0] OKAY   = `WWT_RESP_OKAY;
    localparam logic [1:0] SLVERR = `WWT_RESP_SLVERR;

    logic        aclk       = 1'b0;
    logic        aresetn    = 1'b0;
    logic        debug_mode = 1'b0;
    logic [7:0]  awaddr     = 8'h00;
    logic        awvalid    = 1'b0;
    logic        awready;
    logic [31:0] wdata      = 32'h0000_0000;
    logic [3:0]  wstrb      = 4'hf;
    logic        wvalid     = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready     = 1'b0;
    logic [7:0]  araddr     = 8'h00;
    logic        arvalid    = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready     = 1'b0;
    logic        timeout_nmi;
    logic        watchdog_reset_out;
    logic        irq;
    int          error_cnt   = 0;
    int          checks_done = 0;
    int          cyc         = 0;
    int          t0;
    logic [31:0] d;
    logic [31:0] d2;
    logic [1:0]  r;

    // register cases, one of them unmapped: address, write value, read-back, response
    logic [7:0]  row_a [5] = '{A_MSK, A_REL, A_STS, 8'h18, A_CTRL};
    logic [31:0] row_w [5] = '{32'h0000_0007, 32'h1234_5678, 32'h0000_0007,
                               32'hffff_ffff, 32'h0000_0000};
    logic [31:0] row_r [5] = '{32'h0000_0007, 32'h0000_5678, 32'h0000_0000,
                               32'h0000_0000, 32'h0000_0000};
    logic [1:0]  row_s [5] = '{OKAY, OKAY, OKAY, SLVERR, OKAY};

    wwt_top uut (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .debug_mode         (debug_mode),
        .awaddr             (awaddr),
        .awvalid            (awvalid),
        .awready            (awready),
        .wdata              (wdata),
        .wstrb              (wstrb),
        .wvalid             (wvalid),
        .wready             (wready),
        .bresp              (bresp),
        .bvalid             (bvalid),
        .bready             (bready),
        .araddr             (araddr),
        .arvalid            (arvalid),
        .arready            (arready),
        .rdata              (rdata),
        .rresp              (rresp),
        .rvalid             (rvalid),
        .rready             (rready),
        .timeout_nmi        (timeout_nmi),
        .watchdog_reset_out (watchdog_reset_out),
        .irq                (irq)
    );

    always #25 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc <= cyc + 1;
    end

    task automatic end_sim();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                v = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // waits on nmi (sel 0) or reset output (sel 1); a miss is a mismatch
    task automatic wait_out(input bit sel, input int lim);
        int n;
        n = 0;
        // an unknown level must not end the wait as if it were high
        while ((sel ? watchdog_reset_out : timeout_nmi) !== 1'b1 &&
               n < lim) begin
            @(posedge aclk);
            n++;
        end
        chk({31'h0, n < lim}, 32'h1);
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    initial begin
        repeat (30000) @(posedge aclk);
        error_cnt++;
        end_sim();
    end

    initial begin
        do_reset();
        chk({29'h0, timeout_nmi, watchdog_reset_out, irq}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            axi_rd(row_a[i], d, r);
            chk(d, 32'h0000_0000);
            axi_wr(row_a[i], row_w[i], r);
            chk({30'h0, r}, {30'h0, row_s[i]});
            axi_rd(row_a[i], d, r);
            chk(d, row_r[i]);
            chk({30'h0, r}, {30'h0, row_s[i]});
        end
        // byte lane 0 only: bound byte must keep its old value
        wstrb <= 4'h1;
        axi_wr(A_REL, 32'h0000_abcd, r);
        wstrb <= 4'hf;
        axi_rd(A_REL, d, r);
        chk(d, 32'h0000_56cd);
        // unserviced overflow: ff reload, /2 gives 256 ticks of 2 clocks
        do_reset();
        axi_wr(A_MSK, 32'h0000_0001, r);
        axi_wr(A_REL, 32'h0000_00ff, r);
        axi_wr(A_CTRL, 32'h0000_0001, r);
        t0 = cyc;
        axi_rd(A_CNT, d, r);
        chk({24'h0, d[15:8]}, 32'h0000_00ff);
        wait_out(0, 700);
        chk({31'h0, (cyc - t0) >= 508 && (cyc - t0) <= 516}, 32'h1);
        t0 = cyc;
        @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        axi_wr(A_SVC, 32'h0000_0000, r);
        axi_rd(A_CNT, d, r);
        chk({31'h0, d[16]}, 32'h1);
        axi_rd(A_STS, d, r);
        chk({29'h0, d[2:0]}, 32'h1);
        wait_out(1, 200);
        chk({31'h0, (cyc - t0) >= 94 && (cyc - t0) <= 98}, 32'h1);
        chk({31'h0, timeout_nmi}, 32'h1);
        // timely service keeps the system alive
        do_reset();
        chk({30'h0, timeout_nmi, watchdog_reset_out}, 32'h0);
        axi_wr(A_REL, 32'h0000_00ff, r);
        axi_wr(A_CTRL, 32'h0000_0001, r);
        repeat (300) @(posedge aclk);
        axi_wr(A_SVC, 32'h0000_0000, r);
        axi_rd(A_CNT, d, r);
        chk({31'h0, d[15:8] == 8'hff && d[7:0] < 8'h08}, 32'h1);
        repeat (400) @(posedge aclk);
        chk({31'h0, timeout_nmi}, 32'h0);
        // debug freezes; then the slow prescale
        debug_mode <= 1'b1;
        axi_rd(A_CNT, d, r);
        repeat (200) @(posedge aclk);
        axi_rd(A_CNT, d2, r);
        chk(d2, d);
        debug_mode <= 1'b0;
        axi_wr(A_CTRL, 32'h0000_0003, r);
        axi_wr(A_SVC, 32'h0000_0000, r);
        axi_rd(A_CNT, d, r);
        repeat (1280) @(posedge aclk);
        axi_rd(A_CNT, d2, r);
        d2 = d2 - d;
        chk({31'h0, d2 >= 9 && d2 <= 11}, 32'h1);
        // window off: service inside the span is fine, load uses reload
        do_reset();
        axi_wr(A_REL, 32'h0000_f1f0, r);
        axi_wr(A_CTRL, 32'h0000_0001, r);
        axi_wr(A_SVC, 32'h0000_0000, r);
        axi_rd(A_CNT, d, r);
        chk({23'h0, d[16:8]}, 32'h0000_00f0);
        // window on: outside service reloads from the larger bound
        axi_wr(A_CTRL, 32'h0000_0005, r);
        repeat (600) @(posedge aclk);
        axi_wr(A_SVC, 32'h0000_0000, r);
        axi_rd(A_CNT, d, r);
        chk({23'h0, d[16:8]}, 32'h0000_00f1);
        // refresh inside the window: reset without nmi
        do_reset();
        axi_wr(A_MSK, 32'h0000_0002, r);
        axi_wr(A_REL, 32'h0000_f8f0, r);
        axi_wr(A_CTRL, 32'h0000_0005, r);
        axi_wr(A_SVC, 32'h0000_0000, r);
        wait_out(1, 200);
        chk({31'h0, timeout_nmi}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        axi_rd(A_STS, d, r);
        chk({29'h0, d[2:0]}, 32'h6);
        axi_wr(A_STS, 32'h0000_0002, r);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule
